// ### hw/dcc_channel_control.sv
// DMA channel pair control: registers, request selection, transfer sequencing.
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dcc_channel_control (
    // Clock, reset and power state.
    input wire logic clk,
    input wire logic rst_b,
    input wire logic standby,
    // AXI4-Lite register slave.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Activation events from timer and serial port, and the CPU requests they feed.
    input wire logic [3:0] timerEvent,
    input wire logic txEmptyEvent,
    input wire logic rxFullEvent,
    output logic [3:0] timerIrq,
    output logic txEmptyIrq,
    output logic rxFullIrq,
    // External request pin for channel B, active low.
    input wire logic externalRequestIn_b,
    // End-of-transfer interrupts, index 0 is channel A.
    output logic [1:0] endOfTransferIrq,
    // System bus master port.
    output logic busValid,
    output dcc_pkg::dcc_bus_req_t busReq,
    input wire logic busReady,
    input wire logic [15:0] busRdata
);
    import dcc_pkg::*;

    typedef enum {ST_IDLE, ST_READ, ST_WRITE} dcc_state_t;

    dcc_ctrl_t ctrl_q [2];
    logic [23:0] memAddr_q [2];
    logic [15:0] count_q [2];
    logic [7:0] periphAddr_q [2];
    logic [1:0] armed_q;
    logic [1:0] pending_q;
    logic [1:0] enPrev_q;
    logic [1:0] irq_q;
    dcc_state_t state_q;
    logic cur_q;
    logic [15:0] data_q;
    logic extSync1_q, extSync2_q, extPrev_q;
    logic awHeld_q, wHeld_q, bvalid_q, rvalid_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q, rdata_q;
    logic [3:0] wStrb_q;
    logic [1:0] bresp_q, rresp_q;

    logic fullMode, extFall, extLow, wrDo, arFire, xferDone, terminal, startXfer, grantCh;
    logic [1:0] hit;
    logic [5:0] claim;
    dcc_mode_t curMode;

    ////////////////////////////////////////////////////////////////////////////////
    // Request pin synchroniser; the second stage and its delayed copy feed detection logic.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            extSync1_q <= 1'b1;
            extSync2_q <= 1'b1;
            extPrev_q <= 1'b1;
        end else begin
            extSync1_q <= externalRequestIn_b;
            extSync2_q <= extSync1_q;
            extPrev_q <= extSync2_q;
        end
    end

    // Falling edge and low level seen after synchronising.
    assign extFall = extPrev_q & ~extSync2_q;
    assign extLow = ~extSync2_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode and source decode.
    assign fullMode = (ctrl_q[0].src[2:1] == SRC_FULL_MODE);

    // Source match per channel; code 6/7 on channel A means full mode instead.
    always_comb begin
        hit = 2'b00;
        for (int ch = 0; ch < 2; ch++) begin
            unique case (ctrl_q[ch].src)
                3'h0, 3'h1, 3'h2, 3'h3: hit[ch] = timerEvent[ctrl_q[ch].src[1:0]];
                SRC_TX_EMPTY: hit[ch] = txEmptyEvent;
                SRC_RX_FULL: hit[ch] = rxFullEvent;
                SRC_EXT_FALL: hit[ch] = (ch == 1) && extFall;
                SRC_EXT_LOW: hit[ch] = (ch == 1) && extLow;
            endcase
        end
        // The joined channel runs its transfers back to back on its own.
        if (fullMode) begin
            hit = 2'b01;
        end
    end

    // Events claimed by enabled short-address channels never reach the CPU.
    always_comb begin
        claim = 6'h00;
        for (int ch = 0; ch < 2; ch++) begin
            if (ctrl_q[ch].enable && !fullMode && ctrl_q[ch].src < SRC_EXT_FALL) begin
                claim[ctrl_q[ch].src] = 1'b1;
            end
        end
    end

    assign timerIrq = timerEvent & ~claim[3:0];
    assign txEmptyIrq = txEmptyEvent & ~claim[4];
    assign rxFullIrq = rxFullEvent & ~claim[5];

    ////////////////////////////////////////////////////////////////////////////////
    // Pending requests; a new event in the cycle a transfer starts is kept.
    always_ff @(posedge clk) begin
        if (!rst_b || standby) begin
            pending_q <= 2'b00;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                if (!ctrl_q[ch].enable || (ch == 1 && fullMode)) begin
                    pending_q[ch] <= 1'b0;
                end else if (hit[ch]) begin
                    pending_q[ch] <= 1'b1;
                end else if (startXfer && grantCh == ch[0]) begin
                    pending_q[ch] <= 1'b0;
                end
            end
        end
    end

    // Channel A wins when both are waiting, so a shared source runs A then B.
    assign startXfer = (state_q == ST_IDLE) && (pending_q != 2'b00);
    assign grantCh = !pending_q[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Transfer sequencer: one read then one write per transfer.
    always_ff @(posedge clk) begin
        if (!rst_b || standby) begin
            state_q <= ST_IDLE;
            cur_q <= 1'b0;
            data_q <= 16'h0000;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (startXfer) begin
                        cur_q <= grantCh;
                        state_q <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (busReady) begin
                        data_q <= busRdata;
                        state_q <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (busReady) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign xferDone = (state_q == ST_WRITE) && busReady;
    assign curMode = fullMode ? MODE_IO : dcc_mode(ctrl_q[cur_q]);
    assign terminal = xferDone && curMode != MODE_REPEAT && count_q[cur_q] == COUNT_LAST;

    // Bus request; receive-full activation reads the peripheral side.
    always_comb begin
        logic [31:0] memSide, perSide;
        memSide = {ADDR_TOP, memAddr_q[cur_q]};
        perSide = {PERIPH_UPPER, periphAddr_q[cur_q]};
        busValid = (state_q != ST_IDLE);
        busReq.write = (state_q == ST_WRITE);
        busReq.word = ctrl_q[cur_q].size;
        busReq.wdata = data_q;
        if (fullMode) begin
            busReq.addr = busReq.write ? {ADDR_TOP, memAddr_q[1]} : memSide;
        end else if (ctrl_q[cur_q].src == SRC_RX_FULL) begin
            busReq.addr = busReq.write ? memSide : perSide;
        end else begin
            busReq.addr = busReq.write ? perSide : memSide;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI write channel: address and data are taken independently, then answered.
    assign s_axi_awready = !awHeld_q;
    assign s_axi_wready = !wHeld_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign wrDo = awHeld_q && wHeld_q && !bvalid_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && !awHeld_q) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !wHeld_q) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (wrDo) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (awAddr_q < OFS_LIMIT) ? RESP_OKAY : RESP_DECERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // AXI read channel; data are captured at the address handshake.
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign arFire = s_axi_arvalid && !rvalid_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (arFire) begin
            rvalid_q <= 1'b1;
            rresp_q <= (s_axi_araddr < OFS_LIMIT) ? RESP_OKAY : RESP_DECERR;
            rdata_q <= 32'h0000_0000;
            if (s_axi_araddr < OFS_LIMIT) begin
                unique case (s_axi_araddr[3:2])
                    REG_MAR: rdata_q <= {ADDR_TOP, memAddr_q[s_axi_araddr[4]]};
                    REG_COUNT: rdata_q <= {16'h0000, count_q[s_axi_araddr[4]]};
                    REG_PERIPH: rdata_q <= {24'h000000, periphAddr_q[s_axi_araddr[4]]};
                    REG_CTRL: rdata_q <= {24'h000000, ctrl_q[s_axi_araddr[4]]};
                endcase
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Address and count registers; no reset, so they hold across reset and standby.
    always_ff @(posedge clk) begin
        for (int ch = 0; ch < 2; ch++) begin
            // Hardware update at the end of each transfer.
            if (xferDone && (cur_q == ch[0] || fullMode)) begin
                if (fullMode) begin
                    memAddr_q[ch] <= dcc_step(memAddr_q[ch], ctrl_q[0].size, ctrl_q[0].dir);
                end else if (curMode != MODE_IDLE) begin
                    memAddr_q[ch] <= dcc_step(memAddr_q[ch], ctrl_q[ch].size, ctrl_q[ch].dir);
                end
                if (ch == 0 || !fullMode) begin
                    if (curMode == MODE_REPEAT && count_q[ch][15:8] == HIGH_LAST) begin
                        count_q[ch][15:8] <= count_q[ch][7:0];
                    end else if (curMode == MODE_REPEAT) begin
                        count_q[ch][15:8] <= count_q[ch][15:8] - 8'h01;
                    end else begin
                        count_q[ch] <= count_q[ch] - 16'h0001;
                    end
                end
            end
            // Software write wins over the hardware update in the same cycle.
            if (wrDo && awAddr_q < OFS_LIMIT && awAddr_q[4] == ch[0]) begin
                unique case (awAddr_q[3:2])
                    REG_MAR: begin
                        memAddr_q[ch] <= 24'(dcc_merge({ADDR_TOP, memAddr_q[ch]}, wData_q,
                                                       wStrb_q));
                    end
                    REG_COUNT: begin
                        count_q[ch] <= 16'(dcc_merge({16'h0000, count_q[ch]}, wData_q,
                                                     wStrb_q));
                    end
                    REG_PERIPH: begin
                        periphAddr_q[ch] <= 8'(dcc_merge({24'h000000, periphAddr_q[ch]},
                                                         wData_q, wStrb_q));
                    end
                    REG_CTRL: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers and the read-before-enable guard.
    always_ff @(posedge clk) begin
        if (!rst_b || standby) begin
            ctrl_q[0] <= CTRL_RESET;
            ctrl_q[1] <= CTRL_RESET;
            armed_q <= 2'b00;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                logic [7:0] nv;
                nv = 8'(dcc_merge({24'h000000, ctrl_q[ch]}, wData_q, wStrb_q));
                if (arFire && s_axi_araddr < OFS_LIMIT && s_axi_araddr[3:2] == REG_CTRL &&
                    s_axi_araddr[4] == ch[0] && !ctrl_q[ch].enable) begin
                    armed_q[ch] <= 1'b1;
                end
                if (terminal && cur_q == ch[0]) begin
                    ctrl_q[ch].enable <= 1'b0;
                end
                if (wrDo && awAddr_q < OFS_LIMIT && awAddr_q[4] == ch[0] &&
                    awAddr_q[3:2] == REG_CTRL) begin
                    ctrl_q[ch] <= nv;
                    // A write of one is honoured only once the clear enable was read.
                    ctrl_q[ch].enable <= nv[7] && (ctrl_q[ch].enable || armed_q[ch]);
                    armed_q[ch] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // End-of-transfer interrupt: set on enable falling, held until acknowledged.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            enPrev_q <= 2'b00;
            irq_q <= 2'b00;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                enPrev_q[ch] <= ctrl_q[ch].enable;
                if (enPrev_q[ch] && !ctrl_q[ch].enable && ctrl_q[ch].irqEn) begin
                    irq_q[ch] <= 1'b1;
                end else if (ctrl_q[ch].enable || !ctrl_q[ch].irqEn) begin
                    irq_q[ch] <= 1'b0;
                end
            end
        end
    end

    assign endOfTransferIrq = irq_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the behaviour above.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b || standby);

    a_standby_ctrl_clear: assert property (disable iff (!rst_b) standby |=> ctrl_q[0] == CTRL_RESET && ctrl_q[1] == CTRL_RESET) else $error("control not cleared by standby");
    a_enable_needs_read: assert property ($rose(ctrl_q[0].enable) |-> $past(armed_q[0])) else $error("enable set without prior read");
    a_disabled_no_pend: assert property (!ctrl_q[1].enable |=> !pending_q[1]) else $error("disabled channel holds request");
    a_irq_on_fall: assert property ($fell(ctrl_q[0].enable) && ctrl_q[0].irqEn |=> endOfTransferIrq[0] || !ctrl_q[0].irqEn) else $error("no interrupt on enable fall");
    a_irq_masked: assert property (!ctrl_q[1].irqEn |=> !endOfTransferIrq[1]) else $error("interrupt with enable off");
    a_io_end_clear: assert property (xferDone && !cur_q && !fullMode && curMode == MODE_IO && count_q[0] == COUNT_LAST && !wrDo |=> !ctrl_q[0].enable && count_q[0] == 16'h0000) else $error("I/O mode did not end at zero");
    a_repeat_reload: assert property (xferDone && !cur_q && !fullMode && curMode == MODE_REPEAT && count_q[0][15:8] == HIGH_LAST && !wrDo |=> count_q[0][15:8] == $past(count_q[0][7:0]) && ctrl_q[0].enable) else $error("repeat reload wrong");
    a_idle_addr_hold: assert property (xferDone && !cur_q && !fullMode && curMode == MODE_IDLE && !wrDo |=> $stable(memAddr_q[0])) else $error("idle mode moved address");
    a_word_step_up: assert property (xferDone && !cur_q && !fullMode && curMode == MODE_IO && ctrl_q[0].size && !ctrl_q[0].dir && !wrDo |=> memAddr_q[0] == $past(memAddr_q[0]) + 24'h000002) else $error("word step wrong");
    a_periph_upper: assert property (busValid && !fullMode && busReq.write && ctrl_q[cur_q].src != SRC_RX_FULL |-> busReq.addr[31:8] == PERIPH_UPPER) else $error("peripheral address upper bits");
    a_tx_suppress: assert property (ctrl_q[0].enable && !fullMode && ctrl_q[0].src == SRC_TX_EMPTY |-> !txEmptyIrq) else $error("claimed event reached CPU");
    a_fixed_priority: assert property (state_q == ST_IDLE && pending_q == 2'b11 |=> state_q == ST_READ && !cur_q) else $error("channel B served before A");

    c_repeat_reload: cover property (xferDone && curMode == MODE_REPEAT && count_q[cur_q][15:8] == HIGH_LAST);
    c_full_mode_xfer: cover property (fullMode && xferDone);
    c_ext_edge_start: cover property (ctrl_q[1].src == SRC_EXT_FALL && extFall ##[1:4] startXfer);
    c_irq_raised: cover property ($rose(endOfTransferIrq[0]));
endmodule : dcc_channel_control
`default_nettype wire

// ### include/dcc_pkg.sv
// Shared constants, register layout and types for the DMA channel pair control block.
`default_nettype none
package dcc_pkg;
    // Register map: two channel slots of four words each.
    localparam logic [7:0] OFS_CH_STRIDE = 8'h10;
    localparam logic [1:0] REG_MAR = 2'h0;
    localparam logic [1:0] REG_COUNT = 2'h1;
    localparam logic [1:0] REG_PERIPH = 2'h2;
    localparam logic [1:0] REG_CTRL = 2'h3;
    localparam logic [7:0] OFS_LIMIT = 8'h20;
    // Reset values and fixed address parts.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] ADDR_TOP = 8'hff;
    localparam logic [23:0] PERIPH_UPPER = 24'hffffff;
    localparam logic [15:0] COUNT_LAST = 16'h0001;
    localparam logic [7:0] HIGH_LAST = 8'h01;
    localparam logic [23:0] STEP_BYTE = 24'h000001;
    localparam logic [23:0] STEP_WORD = 24'h000002;
    // Activation source codes.
    localparam logic [2:0] SRC_TX_EMPTY = 3'h4;
    localparam logic [2:0] SRC_RX_FULL = 3'h5;
    localparam logic [2:0] SRC_EXT_FALL = 3'h6;
    localparam logic [2:0] SRC_EXT_LOW = 3'h7;
    localparam logic [1:0] SRC_FULL_MODE = 2'h3;
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Channel control register fields, bit 7 down to bit 0.
    typedef struct packed {
        logic enable;
        logic size;
        logic dir;
        logic repeatSel;
        logic irqEn;
        logic [2:0] src;
    } dcc_ctrl_t;

    typedef enum {MODE_IO, MODE_REPEAT, MODE_IDLE} dcc_mode_t;

    // One request on the system bus.
    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic word;
        logic [15:0] wdata;
    } dcc_bus_req_t;

    // Repeat select and interrupt enable together pick the mode.
    function automatic dcc_mode_t dcc_mode(input dcc_ctrl_t c);
        if (!c.repeatSel) begin
            return MODE_IO;
        end
        return c.irqEn ? MODE_IDLE : MODE_REPEAT;
    endfunction : dcc_mode

    // Byte-lane merge of a bus write into an old register value.
    function automatic logic [31:0] dcc_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : dcc_merge

    // Memory address step: 1 or 2, up or down.
    function automatic logic [23:0] dcc_step(input logic [23:0] a, input logic word,
                                             input logic down);
        logic [23:0] s;
        s = word ? STEP_WORD : STEP_BYTE;
        return down ? a - s : a + s;
    endfunction : dcc_step
endpackage : dcc_pkg
`default_nettype wire

// ### tb/dcc_bus_model.sv
// System bus responder for the channel pair, with a settable wait.
`timescale 1ns/1ps
`default_nettype none
module dcc_bus_model
    import dcc_pkg::*;
(
    // Clock and wait cycles before each answer.
    input wire logic clk,
    input wire logic [1:0] slow,
    // Bus slave side.
    input wire logic busValid,
    input wire dcc_pkg::dcc_bus_req_t busReq,
    output logic busReady = 1'b0,
    output logic [15:0] busRdata = 16'h0,
    // Last write seen: {word, address low 24 bits}, and the write count.
    output logic [31:0] lastWr = 32'h0,
    output int writes = 0
);
    logic [1:0] waitCnt = 2'h0;

    // Read data toggles outside the ready cycle so a late sample shows up.
    always @(posedge clk) begin
        busReady <= 1'b0;
        busRdata <= ~busRdata;
        if (busValid && !busReady) begin
            waitCnt <= waitCnt + 2'h1;
            if (waitCnt == slow) begin
                busReady <= 1'b1;
                busRdata <= busReq.addr[15:0];
                waitCnt <= 2'h0;
                if (busReq.write) begin
                    lastWr <= {7'h0, busReq.word, busReq.addr[23:0]};
                    writes <= writes + 1;
                end
            end
        end
    end
endmodule : dcc_bus_model
`default_nettype wire

// ### tb/tb_top.sv
// Testbench: register access, I/O, repeat and idle transfers, standby.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dcc_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, standby = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, txEmptyEvent = 1'b0;
    logic rxFullEvent = 1'b0, externalRequestIn_b = 1'b1, busValid, busReady, txEmptyIrq, rxFullIrq;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, lastWr;
    logic [3:0] s_axi_wstrb = 4'hf, timerEvent = 4'h0, timerIrq;
    logic [1:0] s_axi_bresp, s_axi_rresp, endOfTransferIrq, slow = 2'h0;
    logic [15:0] busRdata;
    dcc_bus_req_t busReq;
    int writes, mismatches = 0, check_count = 0;

    dcc_channel_control u_dut (.clk, .rst_b, .standby, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timerEvent, .txEmptyEvent, .rxFullEvent,
        .timerIrq, .txEmptyIrq, .rxFullIrq, .externalRequestIn_b, .endOfTransferIrq, .busValid,
        .busReq, .busReady, .busRdata);
    dcc_bus_model u_bus (.clk, .slow, .busValid, .busReq, .busReady, .busRdata, .lastWr, .writes);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Address and data offered together; each released at the edge that takes it.
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wreg

    // Read word and response, compared in two checks: the data, then the zero-extended response.
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
        s_axi_rready <= 1'b0;
    endtask : rchk

    // One event pulse; its CPU copy must stay masked while the channel claims it.
    task automatic pulse(input logic rx, input int n);
        @(posedge clk);
        if (rx) rxFullEvent <= 1'b1; else timerEvent[0] <= 1'b1;
        @(negedge clk);
        chk({31'h0, timerIrq[0] | rxFullIrq}, 32'h0);
        @(posedge clk);
        {rxFullEvent, timerEvent[0]} <= 2'h0;
        wait (writes == n);
        repeat (4) @(posedge clk);
    endtask : pulse

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // Clock, and a watchdog well beyond the roughly 150 cycles the tests need.
    initial forever #25 clk = ~clk;
    initial begin
        repeat (6000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rchk(8'h0c, 32'h0);
        wreg(8'h00, 32'h100);
        rchk(8'h00, 32'hff000100);
        rchk(8'h20, 32'h0, 2'h3);
        wreg(8'h04, 32'h2);
        wreg(8'h08, 32'h40);
        wreg(8'h0c, 32'h08);
        wreg(8'h0c, 32'h88);
        rchk(8'h0c, 32'h08);
        wreg(8'h0c, 32'h88);
        pulse(1'b0, 1);
        chk(lastWr, 32'h00ffff40);
        pulse(1'b0, 2);
        chk({30'h0, endOfTransferIrq}, 32'h1);
        rchk(8'h0c, 32'h08);
        rchk(8'h00, 32'hff000102);
        slow <= 2'h3;
        wreg(8'h10, 32'h200);
        wreg(8'h14, 32'h0102);
        rchk(8'h1c, 32'h0);
        wreg(8'h1c, 32'hf5);
        pulse(1'b1, 3);
        chk(lastWr, 32'h01000200);
        rchk(8'h14, 32'h0202);
        rchk(8'h1c, 32'hf5);
        rchk(8'h10, 32'hff0001fe);
        standby <= 1'b1;
        @(posedge clk);
        standby <= 1'b0;
        rchk(8'h1c, 32'h0);
        rchk(8'h14, 32'h0202);
        wreg(8'h04, 32'h1);
        rchk(8'h0c, 32'h0);
        wreg(8'h0c, 32'hb8);
        pulse(1'b0, 4);
        rchk(8'h00, 32'hff000102);
        rchk(8'h0c, 32'h38);
        chk({30'h0, endOfTransferIrq}, 32'h1);
        wreg(8'h0c, 32'h30);
        @(negedge clk);
        chk({30'h0, endOfTransferIrq}, 32'h0);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
